/* File: inc/ptcu_defines.svh */
// Register indices, field positions, reset values and codes
`ifndef PTCU_DEFINES_SVH
`define PTCU_DEFINES_SVH
// Register indices; byte address is four times the index
`define PTCU_IX_IRQ_CTRL 8'h0B
`define PTCU_IX_PFLAGS 8'h0C
`define PTCU_IX_PCOUNT 8'h11
`define PTCU_IX_PCTRL 8'h12
`define PTCU_IX_EVLOW 8'h15
`define PTCU_IX_EVHIGH 8'h16
`define PTCU_IX_EVCTRL 8'h17
`define PTCU_IX_PENABLE 8'h8C
`define PTCU_IX_PLIMIT 8'h92
// Field positions
`define PTCU_RUN_BIT 2
`define PTCU_PMFLAG_BIT 1
`define PTCU_EVFLAG_BIT 2
// Reset values
`define PTCU_LIMIT_RST 8'hFF
`define PTCU_COUNT_RST 8'h00
`define PTCU_PCTRL_RST 7'h00
`define PTCU_EVCTRL_RST 6'h00
`define PTCU_BYTE_RST 8'h00
// Event unit mode codes
`define PTCU_M_OFF 4'h0
`define PTCU_M_CAP_FALL 4'h4
`define PTCU_M_CAP_RISE 4'h5
`define PTCU_M_CAP_4 4'h6
`define PTCU_M_CAP_16 4'h7
`define PTCU_M_CMP_SET 4'h8
`define PTCU_M_CMP_CLR 4'h9
`define PTCU_M_CMP_TRIG 4'hB
// Last count of each divider before it fires
`define PTCU_CAP4_LAST 4'h3
`define PTCU_CAP16_LAST 4'hF
`define PTCU_DIV1_LAST 4'h0
`define PTCU_DIV4_LAST 4'h3
`define PTCU_DIV16_LAST 4'hF
`endif

/* File: inc/ptcu_pkg.sv */
// Types and mode decoding shared by the unit's modules
package ptcu_pkg;
`include "ptcu_defines.svh"
    typedef enum logic [2:0] {
        PTCU_OFF, PTCU_CAPTURE, PTCU_COMPARE, PTCU_PWM, PTCU_IDLE
    } ptcu_mode_t;

    // Mode field to mode class [R11] [R12]
    function automatic ptcu_mode_t ptcu_mode_class(input logic [3:0] m);
        if (m == `PTCU_M_OFF) return PTCU_OFF;
        case (m[3:2])
            2'h1: return PTCU_CAPTURE;
            2'h2: return PTCU_COMPARE;
            2'h3: return PTCU_PWM;
            default: return PTCU_IDLE;
        endcase
    endfunction
endpackage

/* File: inc/ptcu_cap_if.sv */
// Interface between the register core and the capture edge detector
`timescale 1ns/1ps
interface ptcu_cap_if;
    logic [3:0] mode;
    logic capture;
    modport main (output mode, input capture);
    modport det (input mode, output capture);
endinterface

/* File: logic/ptcu_capture_edge.sv */
// Capture pin synchroniser, edge detector and edge prescaler
`timescale 1ns/1ps
module ptcu_capture_edge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic event_pin,
    ptcu_cap_if.det cap
);
    import ptcu_pkg::*;

    logic sync1_q, sync2_q, prev_q;
    logic [3:0] pre_q, pre_d;
    wire is_cap = (ptcu_mode_class(cap.mode) == PTCU_CAPTURE);
    wire rise = sync2_q & ~prev_q;
    wire fall = ~sync2_q & prev_q;
    wire last = (cap.mode == `PTCU_M_CAP_4) ? (pre_q == `PTCU_CAP4_LAST)
        : (pre_q == `PTCU_CAP16_LAST);
    wire multi = (cap.mode == `PTCU_M_CAP_4) | (cap.mode == `PTCU_M_CAP_16);

    ////////////////////////////////////////////////////////////////////
    // Pin level is sampled whatever its direction, so a port write
    // that drives the pin can trigger a capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= event_pin; // R16
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Counter clears outside capture and after its last count; a direct switch between
    // capture codes keeps its count, which may fire early
    assign pre_d = !is_cap ? 4'h0 // R18
        : !(multi & rise) ? pre_q // R19
        : last ? 4'h0 : pre_q + 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pre_q <= 4'h0;
        else pre_q <= pre_d;
    end

    // Event select per mode code
    assign cap.capture = is_cap & ( // R11
        (cap.mode == `PTCU_M_CAP_FALL) ? fall
        : (cap.mode == `PTCU_M_CAP_RISE) ? rise
        : rise & last);

    ////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_idle_clear: assert property (!is_cap |=> pre_q == 4'h0) // R18
        else $error("edge prescaler not cleared outside capture");
    a_every_fourth: assert property ( // R11
        cap.capture && cap.mode == `PTCU_M_CAP_4 |-> rise && pre_q == 4'h3)
        else $error("divide-by-4 capture off count");
    c_cap16: cover property (cap.capture && cap.mode == `PTCU_M_CAP_16);
endmodule // ptcu_capture_edge

/* File: logic/ptcu_core.sv */
// Period timer and capture/compare unit with APB register access
//
// Functional notes
// [R1] Input divider 1, 4 or 16 by field
// [R2] Count up to limit, then wrap to zero
// [R3] Limit register read/write, resets to all ones
// [R4] Count register read/write, resets to zero
// [R5] Match divider N+1 sets period match flag
// [R6] Run bit 2 gates counting
// [R7] Count/control write or reset zeroes dividers
// [R8] Control write keeps the count value
// [R9] Undivided match pulse goes to serial port
// [R10] Compare uses 16-bit count, PWM period timer
// [R11] Mode decode: off and four capture modes
// [R12] Compare codes set flag; trigger resets count
// [R13] Control bits 5:4 are PWM duty LSBs
// [R14] Capture copies count, sets sticky flag
// [R15] New capture overwrites unread value
// [R16] Edge detect on pin level, any direction
// [R17] Sixteen-bit timer must be synchronous for capture
// [R18] Edge prescaler held zero outside capture
// [R19] Capture code switch keeps edge count
// [R20] Software masks and clears flag after change
// [R21] Software makes pin an input for capture
// [R22] Value and control registers read/write; 7:6 zero
// [R23] Stopped timer holds everything, no match
`timescale 1ns/1ps
module ptcu_core #(
    parameter int PADDR_W = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_pin,
    input wire logic [15:0] free_count16,
    output logic free_count16_reset,
    output logic match_to_serial,
    output logic pwm_reload,
    output logic event_pin_out,
    output logic event_flag,
    output logic period_match_flag,
    output ptcu_pkg::ptcu_mode_t unit_mode
);
    import ptcu_pkg::*;

    logic [7:0] irqc_q, irqc_d, ena_q, ena_d, lim_q, lim_d, cnt_q, cnt_d;
    logic [7:0] evl_q, evl_d, evh_q, evh_d;
    logic [6:0] pctl_q, pctl_d;
    logic [5:0] evc_q, evc_d;
    logic [3:0] pre_q, pre_d, post_q, post_d;
    logic [1:0] dlat_q, dlat_d;
    logic pm_q, pm_d, ev_q, ev_d, cmp_q, cmpo_q, cmpo_d;
    logic [31:0] prdata_q;
    ptcu_cap_if cap ();

    ////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic hit(input logic [7:0] ix);
        return paddr == PADDR_W'({ix, 2'b00});
    endfunction

    wire s_irqc = hit(`PTCU_IX_IRQ_CTRL);
    wire s_flg = hit(`PTCU_IX_PFLAGS);
    wire s_cnt = hit(`PTCU_IX_PCOUNT);
    wire s_pctl = hit(`PTCU_IX_PCTRL);
    wire s_evl = hit(`PTCU_IX_EVLOW);
    wire s_evh = hit(`PTCU_IX_EVHIGH);
    wire s_evc = hit(`PTCU_IX_EVCTRL);
    wire s_ena = hit(`PTCU_IX_PENABLE);
    wire s_lim = hit(`PTCU_IX_PLIMIT);
    wire mapped = s_irqc | s_flg | s_cnt | s_pctl | s_evl | s_evh
        | s_evc | s_ena | s_lim;

    // Zero-wait slave: writes land at the access edge
    wire wr = psel & penable & pwrite & mapped;
    wire setup = psel & ~penable;
    wire wr_irqc = wr & s_irqc;
    wire wr_flg = wr & s_flg;
    wire wr_cnt = wr & s_cnt;
    wire wr_pctl = wr & s_pctl;
    wire wr_evl = wr & s_evl;
    wire wr_evh = wr & s_evh;
    wire wr_evc = wr & s_evc;
    wire wr_ena = wr & s_ena;
    wire wr_lim = wr & s_lim;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////
    // Period timer
    wire run = pctl_q[`PTCU_RUN_BIT];
    wire [1:0] div_sel = pctl_q[1:0];
    wire [3:0] post_sel = pctl_q[6:3];
    wire [3:0] pre_last = div_sel[1] ? `PTCU_DIV16_LAST // R1
        : div_sel[0] ? `PTCU_DIV4_LAST : `PTCU_DIV1_LAST;
    wire tick = run & (pre_q == pre_last); // R6
    wire pmatch = tick & (cnt_q == lim_q); // R2
    wire post_hit = pmatch & (post_q == post_sel); // R5
    wire div_clr = wr_cnt | wr_pctl;
    assign match_to_serial = pmatch; // R9

    // Stopped timer holds both dividers and the count
    assign pre_d = div_clr ? 4'h0 // R7
        : !run ? pre_q // R23
        : tick ? 4'h0 : pre_q + 4'h1;
    assign post_d = div_clr ? 4'h0 // R7
        : !pmatch ? post_q
        : post_hit ? 4'h0 : post_q + 4'h1; // R5
    // Control write leaves the count alone; count write beats a tick
    assign cnt_d = wr_cnt ? pwdata[7:0] // R8
        : pmatch ? 8'h00 // R2
        : tick ? cnt_q + 8'h01 : cnt_q;

    ////////////////////////////////////////////////////////////////////
    // Event unit mode and time bases
    wire [3:0] mode = evc_q[3:0];
    assign unit_mode = ptcu_mode_class(mode); // R11
    wire is_pwm = (unit_mode == PTCU_PWM);
    // Compare watches the 16-bit count, assumed synchronous to pclk
    wire cmp_eq = (unit_mode == PTCU_COMPARE) // R10 R17
        & (free_count16 == {evh_q, evl_q});
    // Match fires once per entry into equality, not every cycle
    wire cmp_hit = cmp_eq & ~cmp_q; // R12
    wire pwm_load = is_pwm & pmatch; // R10
    wire ev_set = cap.capture | cmp_hit; // R14 R12
    assign free_count16_reset = cmp_hit & (mode == `PTCU_M_CMP_TRIG); // R12
    assign pwm_reload = pwm_load;
    assign cap.mode = mode;

    ptcu_capture_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .event_pin(event_pin),
        .cap(cap.det)
    );

    // Capture overwrites unread values and wins over a write
    assign evl_d = cap.capture ? free_count16[7:0] // R14 R15
        : wr_evl ? pwdata[7:0] : evl_q;
    // High byte is read-only in PWM; it reloads at period end
    assign evh_d = cap.capture ? free_count16[15:8] // R14
        : pwm_load ? evl_q // R13
        : (wr_evh & ~is_pwm) ? pwdata[7:0] : evh_q;
    assign dlat_d = pwm_load ? evc_q[5:4] : dlat_q; // R13
    assign evc_d = wr_evc ? pwdata[5:0] : evc_q; // R22
    // Compare output latch; off mode forces it low
    assign cmpo_d = (unit_mode == PTCU_OFF) ? 1'b0 // R11
        : (cmp_hit & mode == `PTCU_M_CMP_SET) ? 1'b1 // R12
        : (cmp_hit & mode == `PTCU_M_CMP_CLR) ? 1'b0 : cmpo_q;
    assign event_pin_out = cmpo_q;

    ////////////////////////////////////////////////////////////////////
    // Sticky flags: a hardware set beats a software clear
    assign pm_d = (wr_flg ? pwdata[`PTCU_PMFLAG_BIT] : pm_q) | post_hit;
    assign ev_d = (wr_flg ? pwdata[`PTCU_EVFLAG_BIT] : ev_q) | ev_set; // R14
    assign period_match_flag = pm_q;
    assign event_flag = ev_q;
    assign irqc_d = wr_irqc ? pwdata[7:0] : irqc_q;
    assign ena_d = wr_ena ? pwdata[7:0] : ena_q;
    assign lim_d = wr_lim ? pwdata[7:0] : lim_q; // R3
    assign pctl_d = wr_pctl ? pwdata[6:0] : pctl_q;

    ////////////////////////////////////////////////////////////////////
    // Read mux; unimplemented bits read zero
    wire [7:0] rd_byte = s_irqc ? irqc_q
        : s_flg ? {5'h00, ev_q, pm_q, 1'b0}
        : s_cnt ? cnt_q // R4
        : s_pctl ? {1'b0, pctl_q}
        : s_evl ? evl_q
        : s_evh ? evh_q
        : s_evc ? {2'h0, evc_q} // R22
        : s_ena ? ena_q
        : s_lim ? lim_q : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Timer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `PTCU_COUNT_RST; // R4
            lim_q <= `PTCU_LIMIT_RST; // R3
            pctl_q <= `PTCU_PCTRL_RST;
            pre_q <= 4'h0; // R7
            post_q <= 4'h0;
            pm_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lim_q <= lim_d;
            pctl_q <= pctl_d;
            pre_q <= pre_d;
            post_q <= post_d;
            pm_q <= pm_d;
        end
    end

    // Event unit state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evl_q <= `PTCU_BYTE_RST;
            evh_q <= `PTCU_BYTE_RST;
            evc_q <= `PTCU_EVCTRL_RST;
            dlat_q <= 2'h0;
            ev_q <= 1'b0;
            cmp_q <= 1'b0;
            cmpo_q <= 1'b0;
        end else begin
            evl_q <= evl_d;
            evh_q <= evh_d;
            evc_q <= evc_d;
            dlat_q <= dlat_d;
            ev_q <= ev_d;
            cmp_q <= cmp_eq;
            cmpo_q <= cmpo_d;
        end
    end

    // Shared bits written at the access edge; read data latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqc_q <= `PTCU_BYTE_RST;
            ena_q <= `PTCU_BYTE_RST;
            prdata_q <= 32'h0000_0000;
        end else begin
            irqc_q <= irqc_d;
            ena_q <= ena_d;
            if (setup) prdata_q <= {24'h00_0000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_wrap_to_zero: assert property (pmatch && !wr_cnt |=> cnt_q == 8'h00) // R2
        else $error("count did not wrap after limit");
    a_count_step: assert property ( // R2
        tick && !pmatch && !wr_cnt |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("count did not step");
    a_div_one: assert property ( // R1
        run && div_sel == 2'h0 && !wr_cnt && !wr_pctl |=> tick)
        else $error("divide-by-1 missed a tick");
    a_div_four: assert property ( // R1
        tick && div_sel == 2'h1 && !wr_pctl |=> !tick [*3])
        else $error("divide-by-4 ticked early");
    a_div_sixteen: assert property ( // R1
        tick && div_sel[1] && !wr_pctl |=> !tick [*8])
        else $error("divide-by-16 ticked early");
    a_post_flag: assert property (post_hit |=> pm_q && post_q == 4'h0) // R5
        else $error("match divider did not set flag");
    a_post_count: assert property ( // R5
        pmatch && !post_hit && !div_clr |=> post_q == $past(post_q) + 4'h1)
        else $error("match divider did not step");
    a_pm_set_wins: assert property ( // R5
        post_hit && wr_flg |=> pm_q)
        else $error("software clear beat a period match");
    a_serial_undivided: assert property ( // R9
        post_hit |-> match_to_serial)
        else $error("serial pulse missing at divided match");

    // Stopped timer: a set flag may stay, but nothing new may arrive
    a_stop_hold: assert property ( // R23
        !run && !wr_cnt && !wr_pctl |=> cnt_q == $past(cnt_q) && !pmatch)
        else $error("stopped timer moved");
    a_stop_dividers: assert property ( // R23
        !run && !div_clr |=> pre_q == $past(pre_q) && post_q == $past(post_q))
        else $error("stopped dividers moved");
    a_ctrl_keeps: assert property (wr_pctl && !tick |=> cnt_q == $past(cnt_q)) // R8
        else $error("control write changed count");
    a_div_cleared: assert property (div_clr |=> pre_q == 4'h0 && post_q == 4'h0) // R7
        else $error("dividers not cleared by write");

    // Register writes land at the access edge
    wire [7:0] wbyte = pwdata[7:0];
    wire [9:0] duty_next = {evl_q, evc_q[5:4]};
    a_limit_write: assert property ( // R3
        wr_lim |=> lim_q == $past(wbyte))
        else $error("period limit write lost");
    a_count_write: assert property ( // R4
        wr_cnt |=> cnt_q == $past(wbyte))
        else $error("period count write lost");
    a_pctl_write: assert property (
        wr_pctl |=> {1'b0, pctl_q} == ($past(wbyte) & 8'h7F))
        else $error("timer control write lost");
    a_evctrl_write: assert property ( // R22
        wr_evc |=> {2'h0, evc_q} == ($past(wbyte) & 8'h3F))
        else $error("event control write lost");
    a_low_write: assert property ( // R22
        wr_evl && !cap.capture |=> evl_q == $past(wbyte))
        else $error("event low write lost");
    a_high_write: assert property ( // R22
        wr_evh && !cap.capture && !is_pwm |=> evh_q == $past(wbyte))
        else $error("event high write lost");
    a_high_readonly: assert property ( // R13
        wr_evh && is_pwm && !pwm_load |=> evh_q == $past(evh_q))
        else $error("event high written in PWM");

    // Event unit
    a_capture_copy: assert property ( // R14
        cap.capture |=> {evh_q, evl_q} == $past(free_count16) && ev_q)
        else $error("capture did not copy count");
    a_flag_sticky: assert property ( // R14
        ev_q && !wr_flg |=> ev_q)
        else $error("event flag cleared without software");
    a_ev_set_wins: assert property ( // R14
        ev_set && wr_flg |=> ev_q)
        else $error("software clear beat an event");
    a_ev_sw_clear: assert property ( // R14
        wr_flg && !wbyte[`PTCU_EVFLAG_BIT] && !ev_set |=> !ev_q)
        else $error("event flag not cleared by software");
    a_cmp_flag: assert property ( // R12
        cmp_hit |=> ev_q && !cmp_hit)
        else $error("compare match missed flag or repeated");
    a_cmp_set_pin: assert property ( // R12
        cmp_hit && mode == `PTCU_M_CMP_SET |=> event_pin_out)
        else $error("compare did not set pin");
    a_cmp_clr_pin: assert property ( // R12
        cmp_hit && mode == `PTCU_M_CMP_CLR |=> !event_pin_out)
        else $error("compare did not clear pin");
    a_off_pin_low: assert property ( // R11
        unit_mode == PTCU_OFF |=> !event_pin_out)
        else $error("off mode left pin latch high");
    a_trigger_reset: assert property ( // R12
        free_count16_reset |-> mode == `PTCU_M_CMP_TRIG && ev_set)
        else $error("trigger without flag or wrong mode");
    a_pwm_base: assert property ( // R10
        pwm_reload |-> match_to_serial && is_pwm)
        else $error("PWM reload off the period timer");
    a_duty_latch: assert property ( // R13
        pwm_load |=> {evh_q, dlat_q} == $past(duty_next))
        else $error("duty value not latched at period end");
    a_ctrl_top_zero: assert property (setup && s_evc |=> prdata_q[7:6] == 2'h0) // R22
        else $error("event control top bits not zero");

    c_capture: cover property (cap.capture ##[1:20] cap.capture);
    c_postscale: cover property (post_hit && post_sel == 4'hF);
    c_trigger: cover property (free_count16_reset);
    c_pwm_load: cover property (pwm_load ##1 evh_q != $past(evh_q));
endmodule // ptcu_core

/* File: verification/ptcu_event_src.sv */
// Event source model driving the capture pin
`timescale 1ns/1ps
module ptcu_event_src (
    input wire logic pclk,
    output logic event_pin
);
    ////////////////////////////////////////////////////////////////
    // Pin idles low; the source drives it, so the level is defined
    initial event_pin = 1'b0;
    // Each pulse holds 3 clocks per level, above the 2-clock minimum
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge pclk);
            event_pin <= 1'b1;
            repeat (3) @(posedge pclk);
            event_pin <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
endmodule // ptcu_event_src

/* File: verification/tb_period_timer_and_capture_unit.sv */
// Self-checking bench for the period timer and capture unit
`timescale 1ns/1ps
`include "ptcu_defines.svh"
module tb_period_timer_and_capture_unit;
    import ptcu_pkg::*;
    typedef struct {logic wr; logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} ptcu_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, event_pin, fc_reset, to_serial, pwm_reload, pin_out;
    logic event_flag, pm_flag, apb_err, seen_rst;
    logic [15:0] free_count16 = 16'h0000;
    logic [7:0] rv, rv2;
    ptcu_mode_t unit_mode;
    int fail_count = 0, checks = 0, cnt;
    ptcu_row_t rows[15];
    logic [3:0] modes[4] = '{`PTCU_M_CAP_FALL, `PTCU_M_CAP_RISE, `PTCU_M_CAP_4, `PTCU_M_CAP_16};
    int need[4] = '{1, 1, 4, 16};
    int per[4] = '{4, 16, 64, 64};
    ////////////////////////////////////////////////////////////////
    always #2.5 pclk = ~pclk;
    ptcu_core ptcu_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_pin(event_pin), .free_count16(free_count16),
        .free_count16_reset(fc_reset), .match_to_serial(to_serial), .pwm_reload(pwm_reload),
        .event_pin_out(pin_out), .event_flag(event_flag), .period_match_flag(pm_flag),
        .unit_mode(unit_mode));
    ptcu_event_src ptcu_event_src_inst (.pclk(pclk), .event_pin(event_pin));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One APB transfer; holds the request until pready is seen high, giving up after 50 clocks
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        r = prdata[7:0];
        apb_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        apb(1'b1, idx, d, r);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] r);
        apb(1'b0, idx, 8'h00, r);
    endtask
    // Counts match pulses over a span of clocks
    task automatic count_match(input int span);
        cnt = 0;
        repeat (span) begin
            @(posedge pclk);
            cnt += to_serial;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
    // Main sequence: table loop, then hand-written cases
    initial begin
        rows = '{'{0, `PTCU_IX_IRQ_CTRL, 0, 8'h00}, '{0, `PTCU_IX_PFLAGS, 0, 8'h00},
            '{0, `PTCU_IX_PCOUNT, 0, 8'h00}, '{0, `PTCU_IX_PCTRL, 0, 8'h00},
            '{0, `PTCU_IX_EVLOW, 0, 8'h00}, '{0, `PTCU_IX_EVHIGH, 0, 8'h00},
            '{0, `PTCU_IX_EVCTRL, 0, 8'h00}, '{0, `PTCU_IX_PENABLE, 0, 8'h00},
            '{0, `PTCU_IX_PLIMIT, 0, 8'hFF}, '{1, `PTCU_IX_PLIMIT, 8'h5A, 8'h5A},
            '{1, `PTCU_IX_PCOUNT, 8'h77, 8'h77}, '{1, `PTCU_IX_PCTRL, 8'hF3, 8'h73},
            '{1, `PTCU_IX_EVLOW, 8'h5A, 8'h5A}, '{1, `PTCU_IX_EVHIGH, 8'h3C, 8'h3C},
            '{1, `PTCU_IX_EVCTRL, 8'hF5, 8'h35}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].idx, rows[i].wd);
            rd(rows[i].idx, rv);
            check($sformatf("reg %0h", rows[i].idx), rv, rows[i].exp);
        end
        // Unmapped place: error response, reads zero
        wr(8'h01, 8'hFF);
        check("unmapped write err", apb_err, 1'b1);
        rd(8'h01, rv);
        check("unmapped read", {apb_err, rv}, 9'h100);
        // Each input divider code against its match period
        wr(`PTCU_IX_EVCTRL, 8'h00);
        wr(`PTCU_IX_PLIMIT, 8'h03);
        for (int ps = 0; ps < 4; ps++) begin
            // Control first: the count write then starts a clean period
            wr(`PTCU_IX_PCTRL, 8'h04 | ps[7:0]);
            wr(`PTCU_IX_PCOUNT, 8'h00);
            count_match(per[ps] * 10 + per[ps] / 2);
            check($sformatf("matches ps %0d", ps), cnt, 10);
        end
        check("match flag 1:1", pm_flag, 1'b1);
        // Output divider 1:4 needs four matches before the flag
        wr(`PTCU_IX_PCTRL, 8'h00);
        wr(`PTCU_IX_PFLAGS, 8'h00);
        wr(`PTCU_IX_PCOUNT, 8'h00);
        wr(`PTCU_IX_PCTRL, 8'h1C);
        cnt = 0;
        for (int n = 0; n < 100 && pm_flag !== 1'b1; n++) begin
            @(posedge pclk);
            #1;
            if (pm_flag !== 1'b1) cnt += to_serial;
        end
        check("matches before flag", cnt, 4);
        // Stopped timer holds; control write keeps the count
        wr(`PTCU_IX_PCTRL, 8'h00);
        wr(`PTCU_IX_PFLAGS, 8'h00);
        rd(`PTCU_IX_PCOUNT, rv);
        count_match(50);
        check("stopped matches", {cnt[7:0], pm_flag}, 9'h000);
        wr(`PTCU_IX_PCTRL, 8'h02);
        rd(`PTCU_IX_PCOUNT, rv2);
        check("count kept", rv2, rv);
        // Every capture mode, entered through the off code
        for (int i = 0; i < 4; i++) begin
            free_count16 <= 16'(16'h1111 * (i + 1));
            wr(`PTCU_IX_EVCTRL, 8'h00);
            wr(`PTCU_IX_PFLAGS, 8'h00);
            wr(`PTCU_IX_EVCTRL, {4'h0, modes[i]});
            #1;
            check("capture class", unit_mode, PTCU_CAPTURE);
            ptcu_event_src_inst.pulse(need[i] - 1);
            repeat (6) @(posedge pclk);
            check($sformatf("early flag %0d", i), event_flag, 1'b0);
            ptcu_event_src_inst.pulse(1);
            repeat (6) @(posedge pclk);
            check($sformatf("capture flag %0d", i), event_flag, 1'b1);
        end
        // Values were never read between captures
        rd(`PTCU_IX_EVLOW, rv);
        rd(`PTCU_IX_EVHIGH, rv2);
        check("captured value", {rv2, rv}, 16'h4444);
        // Off: edges ignored
        wr(`PTCU_IX_EVCTRL, 8'h00);
        wr(`PTCU_IX_PFLAGS, 8'h00);
        ptcu_event_src_inst.pulse(2);
        repeat (6) @(posedge pclk);
        check("off flag", {unit_mode, event_flag}, {PTCU_OFF, 1'b0});
        // Compare codes: pin action, flag, trigger pulse
        for (int c = 0; c < 4; c++) begin
            free_count16 <= 16'h0000;
            wr(`PTCU_IX_EVCTRL, 8'h00);
            wr(`PTCU_IX_EVLOW, 8'h00);
            wr(`PTCU_IX_EVHIGH, 8'h40);
            wr(`PTCU_IX_PFLAGS, 8'h00);
            wr(`PTCU_IX_EVCTRL, 8'h08 + c[7:0]);
            free_count16 <= 16'h4000;
            seen_rst = 1'b0;
            repeat (4) @(posedge pclk) seen_rst |= fc_reset;
            check($sformatf("compare %0d", c), {pin_out, seen_rst, event_flag},
                  {c == 0, c == 3, 1'b1});
        end
        // PWM takes its base from the period timer
        wr(`PTCU_IX_EVCTRL, 8'h0C);
        #1;
        check("pwm class", unit_mode, PTCU_PWM);
        wr(`PTCU_IX_PCOUNT, 8'h00);
        wr(`PTCU_IX_PCTRL, 8'h04);
        cnt = 0;
        repeat (42) @(posedge pclk) cnt += pwm_reload;
        check("pwm reloads", cnt, 10);
        wr(`PTCU_IX_EVHIGH, 8'h99);
        rd(`PTCU_IX_EVHIGH, rv);
        check("pwm high read-only", rv, 8'h00);
        // Second reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PTCU_IX_PLIMIT, rv);
        rd(`PTCU_IX_PCOUNT, rv2);
        check("limit and count after reset", {rv, rv2}, 16'hFF00);
        conclude();
    end
endmodule // tb_period_timer_and_capture_unit
